// ### hw/mem_cmd_sched.sv
// Purpose: controller end that spaces commands for per-bank read timing
// Assumes: one request taken per clock; commands leave one clock after acceptance
// Notes: requests that would break a spacing are held with req_ready_o low
//
// Function
// [RULE_01] A10 high with READ selects auto precharge
// [RULE_02] internal precharge starts AL plus BL/2 later
// [RULE_03] precharge postponed until tRAS and tRTP met
// [RULE_04] tRP counts from actual internal precharge start
// [RULE_05] BL4: activate after AL plus ceil(tRTP+tRP)
// [RULE_06] BL8: activate after AL+2 plus ceil(tRTP+tRP)
// [RULE_07] round tRTP+tRP quotient up, never truncate
// [RULE_08] precharge not before two clocks after prefetch
// [RULE_09] other banks keep working during auto precharge
// [RULE_10] read to other bank after BL/2 clocks
// [RULE_11] write to other bank after BL/2+2 clocks
// [RULE_12] precharge or activate other bank after one clock
// [RULE_13] explicit precharge waits for row-active time
// [RULE_14] read-to-precharge spacing AL+BL/2-2+max(tRTP,2)
// [RULE_15] first read data after AL plus CL
// [RULE_16] no read interruption; spacing keeps bursts whole
// [RULE_17] per-bank counters gate activate and precharge
// [RULE_18] bank countdown armed by read, released when met
`timescale 1ns/10ps
module mem_cmd_sched
  import rd_ap_pkg::*;
#(
  parameter int AL = AL_DEF,
  parameter int CL = CL_DEF,
  parameter int BL = BL_DEF,
  parameter int DW = DW_DEF
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire cmd_t req_kind_i,
  input wire logic [BA_W-1:0] req_bank_i,
  input wire logic req_ap_i,
  output logic req_ready_o,
  output logic [NBANK-1:0] row_open_o,
  output logic rd_valid_o,
  output logic [DW-1:0] rd_data_o,
  mem_cmd_if.ctrl mem
);

  // ************************************************************
  // spacing loads, each is the least spacing minus one
  // ************************************************************
  localparam logic [CW-1:0] RAS_LD = CW'(TRAS_CYC - 1);
  localparam logic [CW-1:0] RCD_LD = CW'(TRCD_CYC - 1);
  localparam logic [CW-1:0] RP_LD = CW'(TRP_CYC - 1);
  localparam logic [CW-1:0] RD2PRE_LD = CW'(AL + BL / 2 - PREFETCH_CYC + RTP_MIN_CYC - 1);
  // internal precharge never starts before prefetch plus two, so tRP may outlast the rounded sum
  localparam int ACT_GAP = (RTP_RP_CYC > RTP_MIN_CYC + TRP_CYC) ? RTP_RP_CYC : RTP_MIN_CYC + TRP_CYC;
  localparam logic [CW-1:0] RDA2ACT_LD = CW'(AL + BL / 2 - PREFETCH_CYC + ACT_GAP - 1);
  localparam logic [CW-1:0] RD2RD_LD = CW'(BL / 2 - 1);
  localparam logic [CW-1:0] RD2WR_LD = CW'(BL / 2 + WR_EXTRA_CYC - 1);

  if (BL != 4 && BL != 8) $error("burst length must be 4 or 8");
  if (AL + BL / 2 + RTP_RP_CYC >= (1 << CW)) $error("counter width too small for spacing");

  logic take;
  logic [NBANK-1:0] ok_vec;

  assign take = req_valid_i & req_ready_o & ce_i;

  // ************************************************************
  // per-bank timers
  // ************************************************************
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic open_q, open_d;
    logic [CW-1:0] ras_q, ras_d, rcd_q, rcd_d, rd2pre_q, rd2pre_d, act_q, act_d;
    logic mine;

    always_comb begin
      mine = take && (req_bank_i == BA_W'(b));
      open_d = open_q;
      ras_d = (ras_q != '0) ? ras_q - 1'b1 : ras_q;
      rcd_d = (rcd_q != '0) ? rcd_q - 1'b1 : rcd_q;
      rd2pre_d = (rd2pre_q != '0) ? rd2pre_q - 1'b1 : rd2pre_q;
      act_d = (act_q != '0) ? act_q - 1'b1 : act_q;
      if (mine) begin
        case (req_kind_i)
          CMD_ACT: begin
            open_d = 1'b1;
            ras_d = RAS_LD; // RULE_17
            rcd_d = RCD_LD;
          end
          CMD_RD: begin
            if (req_ap_i) begin
              open_d = 1'b0; // RULE_01
              act_d = RDA2ACT_LD; // RULE_05 RULE_06 RULE_07
            end else begin
              rd2pre_d = RD2PRE_LD; // RULE_14
            end
          end
          CMD_PRE: begin
            open_d = 1'b0;
            act_d = RP_LD;
          end
          default: open_d = open_q;
        endcase
      end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        open_q <= 1'b0;
        ras_q <= '0;
        rcd_q <= '0;
        rd2pre_q <= '0;
        act_q <= '0;
      end else if (ce_i) begin
        open_q <= open_d;
        ras_q <= ras_d;
        rcd_q <= rcd_d;
        rd2pre_q <= rd2pre_d;
        act_q <= act_d;
      end
    end

    // bank-local readiness for the request kind now offered
    always_comb begin
      case (req_kind_i)
        CMD_ACT: ok_vec[b] = !open_q && act_q == '0; // RULE_05 RULE_06
        CMD_RD: ok_vec[b] = open_q && rcd_q == '0;
        CMD_WR: ok_vec[b] = open_q && rcd_q == '0;
        CMD_PRE: ok_vec[b] = ras_q == '0 && rd2pre_q == '0; // RULE_13 RULE_14
        default: ok_vec[b] = 1'b1;
      endcase
    end

    assign row_open_o[b] = open_q;
  end

  // ************************************************************
  // device-wide column spacing after a read
  // ************************************************************
  logic [CW-1:0] rd_gap_q, rd_gap_d, wr_gap_q, wr_gap_d;

  always_comb begin
    rd_gap_d = (rd_gap_q != '0) ? rd_gap_q - 1'b1 : rd_gap_q;
    wr_gap_d = (wr_gap_q != '0) ? wr_gap_q - 1'b1 : wr_gap_q;
    if (take && req_kind_i == CMD_RD) begin
      rd_gap_d = RD2RD_LD; // RULE_10 RULE_16
      wr_gap_d = RD2WR_LD; // RULE_11
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_gap_q <= '0;
      wr_gap_q <= '0;
    end else if (ce_i) begin
      rd_gap_q <= rd_gap_d;
      wr_gap_q <= wr_gap_d;
    end
  end

  // ************************************************************
  // acceptance
  // ************************************************************
  always_comb begin
    case (req_kind_i)
      CMD_RD: req_ready_o = ok_vec[req_bank_i] && rd_gap_q == '0; // RULE_10 RULE_16
      CMD_WR: req_ready_o = ok_vec[req_bank_i] && wr_gap_q == '0 && rd_gap_q == '0; // RULE_11
      CMD_ACT: req_ready_o = ok_vec[req_bank_i]; // RULE_12
      CMD_PRE: req_ready_o = ok_vec[req_bank_i]; // RULE_12
      default: req_ready_o = 1'b0;
    endcase
  end

  // ************************************************************
  // registered command drive and read capture
  // ************************************************************
  cmd_t cmd_q, cmd_d;
  logic [BA_W-1:0] bank_q, bank_d;
  logic a10_q, a10_d;
  logic rv_q, rv_d;
  logic [DW-1:0] rdat_q, rdat_d;

  always_comb begin
    cmd_d = take ? req_kind_i : CMD_NOP;
    bank_d = take ? req_bank_i : bank_q;
    a10_d = take ? (req_ap_i && req_kind_i == CMD_RD) : 1'b0;
    rv_d = mem.rd_valid;
    rdat_d = mem.rd_valid ? mem.rd_data : rdat_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_q <= CMD_NOP;
      bank_q <= '0;
      a10_q <= 1'b0;
      rv_q <= 1'b0;
      rdat_q <= '0;
    end else if (ce_i) begin
      cmd_q <= cmd_d;
      bank_q <= bank_d;
      a10_q <= a10_d;
      rv_q <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  assign mem.cmd = cmd_q;
  assign mem.bank = bank_q;
  assign mem.a10 = a10_q;
  assign rd_valid_o = rv_q;
  assign rd_data_o = rdat_q;

endmodule : mem_cmd_sched

// ### include/rd_ap_pkg.sv
// Purpose: shared constants and types for the read/auto-precharge timing pair
// Assumes: one command per clock on a 100 MHz command clock
// Notes: times are held in picoseconds so fractional nanoseconds stay exact
package rd_ap_pkg;

  // ************************************************************
  // clock and core times
  // ************************************************************
  localparam int TCK_PS = 10000;
  localparam int TRAS_PS = 40000;
  localparam int TRTP_PS = 7500;
  localparam int TRP_PS = 15000;
  localparam int TRCD_PS = 15000;

  // least times round up to whole cycles
  localparam int TRAS_CYC = (TRAS_PS + TCK_PS - 1) / TCK_PS;
  localparam int TRTP_CYC = (TRTP_PS + TCK_PS - 1) / TCK_PS;
  localparam int TRP_CYC = (TRP_PS + TCK_PS - 1) / TCK_PS;
  localparam int TRCD_CYC = (TRCD_PS + TCK_PS - 1) / TCK_PS;
  localparam int RTP_RP_CYC = (TRTP_PS + TRP_PS + TCK_PS - 1) / TCK_PS;
  localparam int RTP_MIN_CYC = (TRTP_CYC > 2) ? TRTP_CYC : 2;

  // ************************************************************
  // default geometry and latencies
  // ************************************************************
  localparam int AL_DEF = 1;
  localparam int CL_DEF = 3;
  localparam int BL_DEF = 4;
  localparam int NBANK = 8;
  localparam int BA_W = 3;
  localparam int DW_DEF = 16;
  localparam int CW = 6;
  localparam int WR_EXTRA_CYC = 2;
  localparam int PREFETCH_CYC = 2;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE
  } cmd_t;

endpackage : rd_ap_pkg

// ### include/mem_cmd_if.sv
// Purpose: command and read-data wires between controller and memory model
// Assumes: both ends share clk_i; no tri-state on this link
// Notes: a10 high with a read selects auto precharge
`timescale 1ns/10ps
interface mem_cmd_if
  import rd_ap_pkg::*;
#(
  parameter int DW = DW_DEF
);
  cmd_t cmd;
  logic [BA_W-1:0] bank;
  logic a10;
  logic rd_valid;
  logic [DW-1:0] rd_data;

  modport ctrl (output cmd, output bank, output a10, input rd_valid, input rd_data);
  modport dev (input cmd, input bank, input a10, output rd_valid, output rd_data);
endinterface : mem_cmd_if

// ### hw/mem_bank_model.sv
// Purpose: memory-side bank timing with internal auto precharge and read return
// Assumes: controller keeps its spacing; one command per clock
// Notes: each bank runs independently so other banks work during a precharge
`timescale 1ns/10ps
module mem_bank_model
  import rd_ap_pkg::*;
#(
  parameter int AL = AL_DEF,
  parameter int CL = CL_DEF,
  parameter int BL = BL_DEF,
  parameter int DW = DW_DEF
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  mem_cmd_if.dev mem,
  input wire logic [DW-1:0] rd_word_i,
  output logic [NBANK-1:0] bank_open_o,
  output logic [NBANK-1:0] precharging_o,
  output logic [NBANK-1:0] ap_start_o
);

  localparam int RL = AL + CL;
  localparam logic [CW-1:0] RAS_LD = CW'(TRAS_CYC - 1);
  localparam logic [CW-1:0] BURST_LD = CW'(AL + BL / 2 - 1);
  localparam logic [CW-1:0] RTP_LD = CW'(AL + BL / 2 - PREFETCH_CYC + RTP_MIN_CYC - 1);
  localparam logic [CW-1:0] RP_LD = CW'(TRP_CYC - 1);
  localparam logic [CW-1:0] BEAT_LD = CW'(BL / 2 - 1);

  if (BL != 4 && BL != 8) $error("burst length must be 4 or 8");
  if (RL < 2 || RL > 30) $error("read latency out of range");

  typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_AP_WAIT, ST_PRECH} bank_st_t;

  // ************************************************************
  // per-bank state and countdowns
  // ************************************************************
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    bank_st_t st_q, st_d;
    logic [CW-1:0] ras_q, ras_d, burst_q, burst_d, rtp_q, rtp_d, rp_q, rp_d;
    logic hit, start;

    always_comb begin
      hit = (mem.bank == BA_W'(b));
      start = 1'b0;
      st_d = st_q;
      ras_d = (ras_q != '0) ? ras_q - 1'b1 : ras_q;
      burst_d = (burst_q != '0) ? burst_q - 1'b1 : burst_q;
      rtp_d = (rtp_q != '0) ? rtp_q - 1'b1 : rtp_q;
      rp_d = (rp_q != '0) ? rp_q - 1'b1 : rp_q;
      case (st_q)
        ST_IDLE: begin
          if (hit && mem.cmd == CMD_ACT) begin
            st_d = ST_OPEN;
            ras_d = RAS_LD;
          end
        end
        ST_OPEN: begin
          if (hit && mem.cmd == CMD_RD && mem.a10) begin // RULE_01
            st_d = ST_AP_WAIT; // RULE_18
            burst_d = BURST_LD; // RULE_02
            rtp_d = RTP_LD; // RULE_08
          end else if (hit && mem.cmd == CMD_PRE) begin
            st_d = ST_PRECH;
            rp_d = RP_LD;
          end
        end
        ST_AP_WAIT: begin
          // held off until burst point, row-active and read-to-precharge all expire
          if (burst_q == '0 && ras_q == '0 && rtp_q == '0) begin // RULE_03
            start = 1'b1; // RULE_02
            st_d = ST_PRECH;
            rp_d = RP_LD; // RULE_04
          end
        end
        ST_PRECH: begin
          // row may reopen on the edge at which tRP ends
          if (rp_q == '0) begin
            if (hit && mem.cmd == CMD_ACT) begin
              st_d = ST_OPEN;
              ras_d = RAS_LD;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        st_q <= ST_IDLE;
        ras_q <= '0;
        burst_q <= '0;
        rtp_q <= '0;
        rp_q <= '0;
      end else if (ce_i) begin
        st_q <= st_d; // RULE_09
        ras_q <= ras_d;
        burst_q <= burst_d;
        rtp_q <= rtp_d;
        rp_q <= rp_d;
      end
    end

    assign bank_open_o[b] = (st_q == ST_OPEN) || (st_q == ST_AP_WAIT);
    assign precharging_o[b] = (st_q == ST_PRECH);
    assign ap_start_o[b] = start & ce_i;
  end

  // ************************************************************
  // read return after read latency
  // ************************************************************
  logic [RL-1:0] pipe_q, pipe_d;
  logic [CW-1:0] beat_q, beat_d;
  logic valid_q, valid_d;
  logic [DW-1:0] data_q, data_d;

  always_comb begin
    pipe_d = {pipe_q[RL-2:0], mem.cmd == CMD_RD};
    beat_d = beat_q;
    valid_d = valid_q;
    data_d = data_q;
    if (pipe_q[RL-1]) begin // RULE_15
      valid_d = 1'b1;
      beat_d = BEAT_LD;
      data_d = rd_word_i;
    end else if (valid_q && beat_q != '0) begin
      beat_d = beat_q - 1'b1;
      data_d = rd_word_i;
    end else begin
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pipe_q <= '0;
      beat_q <= '0;
      valid_q <= 1'b0;
      data_q <= '0;
    end else if (ce_i) begin
      pipe_q <= pipe_d;
      beat_q <= beat_d;
      valid_q <= valid_d;
      data_q <= data_d;
    end
  end

  assign mem.rd_valid = valid_q;
  assign mem.rd_data = data_q;

endmodule : mem_bank_model

// ### testbench/rd_ap_chk.sv
// Purpose: link timing checks between controller and memory end
// Assumes: default latencies and burst length 4
// Notes: watches link wires only
`timescale 1ns/10ps
module rd_ap_chk
  import rd_ap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire cmd_t cmd,
  input wire logic [BA_W-1:0] bank,
  input wire logic a10,
  input wire logic rd_valid
);
  // ************************************************************
  // command spacing and read return
  // ************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_rd_lat;
    cmd == CMD_RD |-> ##5 rd_valid [*2];
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late or short");

  property p_rd_src;
    !rd_valid ##1 rd_valid |-> $past(cmd, 5) == CMD_RD;
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("read data without read");

  property p_rd_run;
    rd_valid |-> $past(cmd, 5) == CMD_RD || $past(cmd, 6) == CMD_RD;
  endproperty
  a_rd_run: assert property (p_rd_run) else $error("read burst too long");

  property p_rd_rd;
    cmd == CMD_RD |=> cmd != CMD_RD;
  endproperty
  a_rd_rd: assert property (p_rd_rd) else $error("reads too close");

  property p_rd_wr;
    cmd == CMD_RD |=> cmd != CMD_WR [*3];
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("write too soon after read");

  property p_rda_act;
    cmd == CMD_RD && a10 |=> !(cmd == CMD_ACT && bank == $past(bank, 1))
      ##1 !(cmd == CMD_ACT && bank == $past(bank, 2)) ##1 !(cmd == CMD_ACT && bank == $past(bank, 3));
  endproperty
  a_rda_act: assert property (p_rda_act) else $error("activate too soon after auto precharge");

  property p_rd_pre;
    cmd == CMD_RD |=> !(cmd == CMD_PRE && bank == $past(bank, 1))
      ##1 !(cmd == CMD_PRE && bank == $past(bank, 2));
  endproperty
  a_rd_pre: assert property (p_rd_pre) else $error("precharge too soon after read");

  property p_act_pre;
    cmd == CMD_ACT |=> !(cmd == CMD_PRE && bank == $past(bank, 1))
      ##1 !(cmd == CMD_PRE && bank == $past(bank, 2)) ##1 !(cmd == CMD_PRE && bank == $past(bank, 3));
  endproperty
  a_act_pre: assert property (p_act_pre) else $error("precharge before row active time");
endmodule : rd_ap_chk

// ### testbench/tb_top.sv
// Purpose: drives controller into memory end and judges link timing
// Assumes: default latencies, burst length 4
// Notes: events stamped at falling edges
`timescale 1ns/10ps
module tb_top;
  import rd_ap_pkg::*;
  // precharge start bounded below by prefetch plus two, then tRP
  localparam int ACT_AFTER_RDA = AL_DEF + BL_DEF / 2 - 2 +
    ((RTP_RP_CYC > RTP_MIN_CYC + TRP_CYC) ? RTP_RP_CYC : RTP_MIN_CYC + TRP_CYC);
  // ************************************************************
  // bench
  // ************************************************************
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic req_valid_i = 1'b0;
  cmd_t req_kind_i = CMD_NOP;
  logic [BA_W-1:0] req_bank_i = 3'h0;
  logic req_ap_i = 1'b0;
  logic [15:0] rd_word_i = 16'hA5C3;
  logic req_ready_o;
  logic rd_valid_o;
  logic [15:0] rd_data_o;
  logic [NBANK-1:0] row_open_o, bank_open_o, ap_start_o, ap_seen;
  logic val_q = 1'b0;
  int bad_count = 0, checks = 0, cyc = 0, t_rd = 0, p_rd = 0, t_wr = 0, t_act = 0, t_pre = 0, t_ap = 0, t_val = 0;
  int n_beat = 0;

  always #5 clk_i = ~clk_i;
  mem_cmd_if #(.DW(16)) link ();
  mem_cmd_sched mem_cmd_sched_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_kind_i(req_kind_i), .req_bank_i(req_bank_i), .req_ap_i(req_ap_i), .req_ready_o(req_ready_o),
    .row_open_o(row_open_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .mem(link));
  mem_bank_model mem_bank_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .mem(link),
    .rd_word_i(rd_word_i), .bank_open_o(bank_open_o), .precharging_o(), .ap_start_o(ap_start_o));
  rd_ap_chk rd_ap_chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd(link.cmd), .bank(link.bank),
    .a10(link.a10), .rd_valid(link.rd_valid));

  always @(negedge clk_i) begin
    cyc++;
    case (link.cmd)
      CMD_RD: begin p_rd = t_rd; t_rd = cyc; end
      CMD_WR: t_wr = cyc;
      CMD_ACT: t_act = cyc;
      CMD_PRE: t_pre = cyc;
      default: ;
    endcase
    if (ap_start_o !== 8'h00) begin t_ap = cyc; ap_seen = ap_seen | ap_start_o; end
    if (link.rd_valid === 1'b1 && val_q !== 1'b1) t_val = cyc;
    val_q = link.rd_valid;
    if (rd_valid_o === 1'b1) n_beat++;
    if (cyc > 1000) begin bad_count++; stop_test(); end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin bad_count++; $display("ERROR %0t: got %0h want %0h", $time, seen, exp); end
  endtask : check

  task issue(input cmd_t k, input logic [2:0] b, input logic ap);
    int n;
    n = 0;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_kind_i = k;
    req_bank_i = b;
    req_ap_i = ap;
    #1;
    while (req_ready_o !== 1'b1 && n < 50) begin @(negedge clk_i); #1; n++; end
    if (n >= 50) begin bad_count++; $display("ERROR %0t: request never ready", $time); end
    @(posedge clk_i);
  endtask : issue

  task idle(input int n);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    repeat (n) @(negedge clk_i);
  endtask : idle

  task t_same_bank;
    ap_seen = 8'h00;
    issue(CMD_ACT, 3'h2, 1'b0);
    issue(CMD_RD, 3'h2, 1'b1);
    issue(CMD_ACT, 3'h2, 1'b0);
    idle(10);
    check(t_ap - t_rd, AL_DEF + BL_DEF / 2);
    check(t_act - t_rd, ACT_AFTER_RDA);
    // command stamped in the cycle before its taking edge, data in the cycle after its edge
    check(t_val - t_rd, AL_DEF + CL_DEF + 1);
    check(n_beat, BL_DEF / 2);
    check(ap_seen, 8'h04);
    check(rd_data_o, 16'hA5C3);
    check(bank_open_o, 8'h04);
    $display("test same_bank done");
  endtask : t_same_bank

  task t_other_banks;
    ap_seen = 8'h00;
    n_beat = 0;
    issue(CMD_ACT, 3'h0, 1'b0);
    issue(CMD_ACT, 3'h1, 1'b0);
    idle(2);
    issue(CMD_RD, 3'h0, 1'b1);
    issue(CMD_ACT, 3'h4, 1'b0);
    issue(CMD_WR, 3'h1, 1'b0);
    idle(4);
    check(t_act - t_rd, 1);
    check(t_wr - t_rd, BL_DEF / 2 + 2);
    issue(CMD_RD, 3'h1, 1'b1);
    issue(CMD_RD, 3'h4, 1'b1);
    idle(12);
    check(t_rd - p_rd, BL_DEF / 2);
    check(ap_seen, 8'h13);
    check(bank_open_o, 8'h04);
    check(row_open_o, 8'h04);
    check(n_beat, 3 * BL_DEF / 2);
    $display("test other_banks done");
  endtask : t_other_banks

  task t_explicit_pre;
    ap_seen = 8'h00;
    issue(CMD_ACT, 3'h5, 1'b0);
    issue(CMD_RD, 3'h5, 1'b0);
    issue(CMD_PRE, 3'h5, 1'b0);
    idle(6);
    check(t_pre - t_rd, AL_DEF + BL_DEF / 2 - 2 + RTP_MIN_CYC);
    issue(CMD_ACT, 3'h6, 1'b0);
    issue(CMD_PRE, 3'h6, 1'b0);
    idle(6);
    check(t_pre - t_act, TRAS_CYC);
    check(ap_seen, 8'h00);
    check(row_open_o, 8'h04);
    $display("test explicit_pre done");
  endtask : t_explicit_pre

  task t_freeze;
    issue(CMD_ACT, 3'h7, 1'b0);
    idle(1);
    ce_i = 1'b0;
    repeat (6) @(negedge clk_i);
    check(row_open_o, 8'h84);
    ce_i = 1'b1;
    issue(CMD_PRE, 3'h7, 1'b0);
    idle(4);
    check(t_pre - t_act, TRAS_CYC + 6);
    check(bank_open_o, 8'h04);
    $display("test freeze done");
  endtask : t_freeze

  task stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    t_same_bank();
    t_other_banks();
    t_explicit_pre();
    t_freeze();
    stop_test();
  end
endmodule : tb_top
